// ### rtl/lcs_pkg.sv
// Constants, states and carriers for the lithium charge sequencer.
package lcs_pkg;
    // Clock rate and the times that the sequencer enforces.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SEC_PERIOD_S = 1;
    localparam int unsigned SEC_TICK_CYCLES = CLK_HZ * SEC_PERIOD_S;
    localparam int unsigned PREQ_LIMIT_HOURS = 1;
    localparam int unsigned SAFETY_LIMIT_HOURS = 10;
    localparam int unsigned TOPOFF_MINUTES = 21;
    localparam logic [15:0] PREQ_LIMIT_SEC = 16'(PREQ_LIMIT_HOURS * 3600);
    localparam logic [15:0] SAFETY_LIMIT_SEC = 16'(SAFETY_LIMIT_HOURS * 3600);
    localparam logic [15:0] TOPOFF_SEC = 16'(TOPOFF_MINUTES * 60);

    // Register offsets and reset values.
    localparam logic [7:0] CHG_CTL_OFS = 8'h01;
    localparam logic [7:0] SUPV_OFS = 8'h02;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h05;
    localparam logic [7:0] CHG_CTL_RST = 8'h43;
    localparam logic [1:0] LED_RST = 2'h3;
    localparam logic TRANGE_RST = 1'b0;

    // Field positions.
    localparam int unsigned VTERM_LSB = 6;
    localparam int unsigned ICC_LSB = 2;
    localparam int unsigned EN_BIT = 1;
    localparam int unsigned EOC_BIT = 0;
    localparam int unsigned STAT_LSB = 0;
    localparam int unsigned TRANGE_BIT = 3;
    localparam int unsigned LED_LSB = 4;
    localparam int unsigned IRQ_TMO_BIT = 0;

    // Current scaling in mA.
    localparam logic [10:0] MA_STEP = 11'h064;
    localparam logic [10:0] MA_TENTH = 11'h00A;
    localparam logic [10:0] MA_TWENTIETH = 11'h005;
    localparam logic [10:0] MA_USB_PREQ = 11'h032;

    // Reported status codes.
    localparam logic [2:0] STS_OFF = 3'h0;
    localparam logic [2:0] STS_PREQ = 3'h1;
    localparam logic [2:0] STS_CC = 3'h2;
    localparam logic [2:0] STS_CV = 3'h3;
    localparam logic [2:0] STS_FAULT = 3'h4;
    localparam logic [2:0] STS_DONE = 3'h5;
    localparam logic [2:0] STS_TMO = 3'h6;
    localparam logic [2:0] STS_TOPOFF = 3'h7;

    // Gray-coded along off, prequal, CC, CV, top-off, complete.
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_PREQ = 3'b001,
        ST_CC = 3'b011,
        ST_CV = 3'b010,
        ST_TOPOFF = 3'b110,
        ST_DONE = 3'b111,
        ST_FAULT = 3'b101,
        ST_TMO = 3'b100
    } lcs_state_t;

    // Comparator and pin levels from the analog side.
    typedef struct packed {
        logic adapter_supply_input;
        logic usb_supply_input;
        logic usb_suspend;
        logic fullrate_qualify_threshold;
        logic batt_at_vterm;
        logic batt_at_eoc;
        logic batt_below_restart;
        logic temp_cold;
        logic temp_hot45;
        logic temp_hot50;
        logic thermal_shutdown;
    } lcs_sense_t;

    // Commands to the power stage.
    typedef struct packed {
        logic charge_on;
        logic cv_mode;
        logic [10:0] current_ma;
        logic [10:0] eoc_ma;
        logic [1:0] vterm_sel;
    } lcs_drive_t;
endpackage

// ### rtl/lcs_charge_sequencer.sv
// Charge sequencer with control registers, safety timer and timeout request.
`timescale 1ns/1ns
`default_nettype none

// Contract
// R1: Bits 7:6 select termination voltage, reset 01.
// R2: Bits 5:2 select current in 100 mA steps.
// R3: Bit 0 selects 5% or 10% end threshold.
// R4: Enable bit stops charging; status reads zero.
// R5: Stay prequalifying, status 001, until threshold reached.
// R6: Prequal current is 10% adapter, 50 mA USB.
// R7: Constant current uses programmed current, status 010.
// R8: Termination voltage reached enters CV, status 011.
// R9: End current starts 21 minute top-off, status 111.
// R10: Cycle complete stops charging, status 101.
// R11: Below restart threshold returns to constant current.
// R12: Supervisor bit picks 50 or 45 degree window.
// R13: Temperature outside window suspends charging, status 100.
// R14: Floating thermistor counts as cold and disables.
// R15: Prequalification limited to one hour.
// R16: Whole charge limited to ten hours total.
// R17: Timer expiry raises request and sticky status.
// R18: Listed events clear and restart the timer.
// R19: After expiry charging stays off until restart.
module lcs_charge_sequencer
    import lcs_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog sense levels, asynchronous.
    input wire lcs_sense_t sense_async,
    // Power stage commands and status.
    output lcs_drive_t drive,
    output logic charge_state_bit2,
    output logic charge_state_bit1,
    output logic charge_state_bit0,
    output logic irq
);

    lcs_sense_t meta_q;
    lcs_sense_t sns_q;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic trange_q;
    logic [1:0] led_q;
    logic tmo_flag_q;
    logic [7:0] rdata_q;
    lcs_state_t state_q;
    lcs_state_t state_d;
    lcs_drive_t drive_q;
    lcs_drive_t drive_d;
    logic [2:0] sts_q;
    logic [2:0] sts_d;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic [15:0] safe_cnt_q;
    logic [15:0] top_cnt_q;
    logic pwr_q;
    logic src_q;
    logic en_q;
    logic tsd_q;
    logic tfault_q;
    logic susp_q;
    logic pwr;
    logic usb_src;
    logic en;
    logic tfault;
    logic recharge;
    logic restart_evt;
    logic [10:0] step;
    logic wr_ctl;
    logic wr_supv;
    logic wr_irq;

    // Two-stage synchroniser; only the second stage feeds any logic.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sns_q <= '0;
        end else begin
            meta_q <= sense_async;
            sns_q <= meta_q;
        end
    end

    // Address decode for the register port.
    assign wr_ctl = reg_wr_en && (reg_addr == CHG_CTL_OFS);
    assign wr_supv = reg_wr_en && (reg_addr == SUPV_OFS);
    assign wr_irq = reg_wr_en && (reg_addr == IRQ_STAT_OFS);

    // Next control value, so the current, end-current and voltage commands track a write without lag.
    assign ctl_d = wr_ctl ? reg_wdata : ctl_q;

    // R1 R2 R3 R4: control fields reset to 0x43.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= CHG_CTL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // R12: window select and LED bits in the supervisor register.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trange_q <= TRANGE_RST;
            led_q <= LED_RST;
        end else if (wr_supv) begin
            trange_q <= reg_wdata[TRANGE_BIT];
            led_q <= reg_wdata[LED_LSB +: 2];
        end
    end

    // R17: timeout flag; a new expiry wins over a write-one clear.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_flag_q <= 1'b0;
        end else if (state_d == ST_TMO && state_q != ST_TMO) begin
            tmo_flag_q <= 1'b1;
        end else if (wr_irq && reg_wdata[IRQ_TMO_BIT]) begin
            tmo_flag_q <= 1'b0;
        end
    end

    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else if (reg_rd_en) begin
            case (reg_addr)
                CHG_CTL_OFS: rdata_q <= ctl_q;
                SUPV_OFS: rdata_q <= {2'b00, led_q, trange_q, sts_q};
                IRQ_STAT_OFS: rdata_q <= {7'h00, tmo_flag_q};
                default: rdata_q <= '0;
            endcase
        end
    end

    // One-second tick; the period is a parameter so simulation can shrink it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt_q == 32'(SEC_CYCLES - 1));

    // A suspended USB input does not count as a supply.
    assign pwr = sns_q.adapter_supply_input
        || (sns_q.usb_supply_input && !sns_q.usb_suspend);
    assign usb_src = !sns_q.adapter_supply_input;
    assign en = ctl_q[EN_BIT];
    // R14: a floating thermistor shows up as cold and so as a fault.
    assign tfault = sns_q.temp_cold || sns_q.thermal_shutdown
        || (trange_q ? sns_q.temp_hot45 : sns_q.temp_hot50);
    assign recharge = (state_q == ST_DONE) && sns_q.batt_below_restart
        && pwr && en && !tfault;

    // History of the conditions whose edges restart the timer.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_q <= 1'b0;
            src_q <= 1'b0;
            en_q <= 1'b1;
            tsd_q <= 1'b0;
            tfault_q <= 1'b0;
            susp_q <= 1'b0;
        end else begin
            pwr_q <= pwr;
            src_q <= usb_src;
            en_q <= en;
            tsd_q <= sns_q.thermal_shutdown;
            tfault_q <= tfault;
            susp_q <= sns_q.usb_suspend;
        end
    end

    // R18: power-on, source swap, recharge, enable toggle, fault exits.
    assign restart_evt = (pwr && !pwr_q)
        || (pwr && pwr_q && (usb_src != src_q))
        || recharge
        || (en != en_q)
        || (tsd_q && !sns_q.thermal_shutdown)
        || (tfault_q && !tfault && en)
        || (susp_q && !sns_q.usb_suspend && sns_q.usb_supply_input && usb_src);

    // R15 R16: one counter covers prequal and the ten-hour total.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            safe_cnt_q <= '0;
        end else if (restart_evt) begin
            safe_cnt_q <= '0;
        end else if (tick && state_q inside {ST_PREQ, ST_CC, ST_CV, ST_TOPOFF}
                     && safe_cnt_q < SAFETY_LIMIT_SEC) begin
            safe_cnt_q <= safe_cnt_q + 16'h0001;
        end
    end

    // R9: top-off interval counted only while topping off.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            top_cnt_q <= '0;
        end else if (state_q != ST_TOPOFF) begin
            top_cnt_q <= '0;
        end else if (tick && top_cnt_q < TOPOFF_SEC) begin
            top_cnt_q <= top_cnt_q + 16'h0001;
        end
    end

    // Sequencer; supply, enable and temperature take priority in that order.
    always_comb begin
        state_d = state_q;
        if (!pwr || !en) begin
            // R4 disable forces off.
            state_d = ST_OFF;
        end else if (tfault) begin
            // R13 temperature suspend.
            state_d = ST_FAULT;
        end else begin
            case (state_q)
                ST_OFF, ST_FAULT: state_d = ST_PREQ;
                ST_PREQ: begin
                    // R15 R5 prequal exit.
                    if (safe_cnt_q >= PREQ_LIMIT_SEC) begin
                        state_d = ST_TMO;
                    end else if (sns_q.fullrate_qualify_threshold) begin
                        state_d = ST_CC;
                    end
                end
                ST_CC: begin
                    // R16 R8 full-rate exit.
                    if (safe_cnt_q >= SAFETY_LIMIT_SEC) begin
                        state_d = ST_TMO;
                    end else if (sns_q.batt_at_vterm) begin
                        state_d = ST_CV;
                    end
                end
                ST_CV: begin
                    // R16 R9 end current reached.
                    if (safe_cnt_q >= SAFETY_LIMIT_SEC) begin
                        state_d = ST_TMO;
                    end else if (sns_q.batt_at_eoc) begin
                        state_d = ST_TOPOFF;
                    end
                end
                ST_TOPOFF: begin
                    // R16 R9 top-off completion.
                    if (safe_cnt_q >= SAFETY_LIMIT_SEC) begin
                        state_d = ST_TMO;
                    end else if (top_cnt_q == TOPOFF_SEC) begin
                        state_d = ST_DONE;
                    end
                end
                ST_DONE: begin
                    // R11 recharge straight to full rate.
                    if (recharge) begin
                        state_d = ST_CC;
                    end
                end
                ST_TMO: begin
                    // R19 hold until a restart event.
                    if (restart_evt) begin
                        state_d = ST_PREQ;
                    end
                end
                default: state_d = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Current targets in mA from the programmed step.
    assign step = {7'h00, ctl_d[ICC_LSB +: 4]} + 11'h001;

    // Drive and status decode from the next state, registered below.
    always_comb begin
        drive_d = '0;
        sts_d = STS_OFF;
        // R1 R3 voltage and end threshold select.
        drive_d.vterm_sel = ctl_d[VTERM_LSB +: 2];
        drive_d.eoc_ma = 11'(step * (ctl_d[EOC_BIT] ? MA_TENTH : MA_TWENTIETH));
        case (state_d)
            ST_PREQ: begin
                // R6 prequal current by source.
                drive_d.charge_on = 1'b1;
                drive_d.current_ma = usb_src ? MA_USB_PREQ : 11'(step * MA_TENTH);
                sts_d = STS_PREQ;
            end
            ST_CC: begin
                // R2 R7 full-rate current.
                drive_d.charge_on = 1'b1;
                drive_d.current_ma = 11'(step * MA_STEP);
                sts_d = STS_CC;
            end
            ST_CV, ST_TOPOFF: begin
                drive_d.charge_on = 1'b1;
                drive_d.cv_mode = 1'b1;
                drive_d.current_ma = 11'(step * MA_STEP);
                sts_d = (state_d == ST_CV) ? STS_CV : STS_TOPOFF;
            end
            // R10 complete is off whatever the enable says.
            ST_DONE: sts_d = STS_DONE;
            ST_FAULT: sts_d = STS_FAULT;
            ST_TMO: sts_d = STS_TMO;
            default: sts_d = STS_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            drive_q <= '0;
            sts_q <= STS_OFF;
        end else begin
            drive_q <= drive_d;
            sts_q <= sts_d;
        end
    end

    assign drive = drive_q;
    assign reg_rdata = rdata_q;
    assign charge_state_bit2 = sts_q[2];
    assign charge_state_bit1 = sts_q[1];
    assign charge_state_bit0 = sts_q[0];
    // R17 request follows the sticky flag until software clears it.
    assign irq = tmo_flag_q;

    // Checks on the sequencer's observable behaviour.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_disabled_status;
        !en && !$rose(en) |=> sts_q == STS_OFF && !drive_q.charge_on;
    endproperty
    a_disabled_status: assert property (p_disabled_status) else $error("disabled not off"); // R4

    property p_done_off;
        state_q == ST_DONE |-> !drive_q.charge_on && sts_q == STS_DONE;
    endproperty
    a_done_off: assert property (p_done_off) else $error("complete still charging"); // R10

    property p_preq_current;
        state_q == ST_PREQ |-> sts_q == STS_PREQ && drive_q.current_ma ==
            (src_q ? MA_USB_PREQ : 11'(({7'h00, ctl_q[ICC_LSB +: 4]} + 11'h001) * MA_TENTH));
    endproperty
    a_preq_current: assert property (p_preq_current) else $error("prequal current wrong"); // R6

    property p_cc_current;
        state_q == ST_CC |-> sts_q == STS_CC && drive_q.current_ma ==
            11'(({7'h00, ctl_q[ICC_LSB +: 4]} + 11'h001) * MA_STEP);
    endproperty
    a_cc_current: assert property (p_cc_current) else $error("full-rate current wrong"); // R7

    property p_fault;
        pwr && en && tfault |=> sts_q == STS_FAULT && !drive_q.charge_on;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not suspended"); // R13

    property p_cv_entry;
        state_q == ST_CC && pwr && en && !tfault && sns_q.batt_at_vterm
            && safe_cnt_q < SAFETY_LIMIT_SEC |=> sts_q == STS_CV && drive_q.cv_mode;
    endproperty
    a_cv_entry: assert property (p_cv_entry) else $error("CV not entered"); // R8

    property p_topoff_len;
        state_q == ST_DONE && $past(state_q) == ST_TOPOFF |-> $past(top_cnt_q) == TOPOFF_SEC;
    endproperty
    a_topoff_len: assert property (p_topoff_len) else $error("top-off interval wrong"); // R9

    property p_preq_limit;
        state_q == ST_PREQ |-> safe_cnt_q <= PREQ_LIMIT_SEC;
    endproperty
    a_preq_limit: assert property (p_preq_limit) else $error("prequal overran"); // R15

    property p_timeout_irq;
        state_q != ST_TMO ##1 state_q == ST_TMO |-> irq && sts_q == STS_TMO;
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("no timeout request"); // R17

    property p_restart_clear;
        restart_evt |=> safe_cnt_q == 16'h0000;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("timer not cleared"); // R18

    property p_recharge;
        recharge |=> state_q == ST_CC;
    endproperty
    a_recharge: assert property (p_recharge) else $error("recharge missed"); // R11

    property p_tmo_hold;
        state_q == ST_TMO && !restart_evt |=> !drive_q.charge_on;
    endproperty
    a_tmo_hold: assert property (p_tmo_hold) else $error("charging after expiry"); // R19

    cover property (state_q == ST_TOPOFF ##1 state_q == ST_DONE);
    cover property (state_q == ST_DONE ##1 state_q == ST_CC);
    cover property (state_q == ST_PREQ ##1 state_q == ST_TMO);
    cover property (state_q == ST_FAULT ##1 state_q == ST_PREQ);

endmodule

`default_nettype wire

// ### bench/lcs_analog_model.sv
// Behavioural power stage and battery comparators facing the sequencer.
`timescale 1ns/1ns
`default_nettype none
module lcs_analog_model
    import lcs_pkg::*;
(
    // Supply, battery and thermistor conditions set by the bench.
    input wire lcs_sense_t env,
    // Commands from the sequencer.
    input wire lcs_drive_t drive,
    // Comparator levels back to the sequencer.
    output var lcs_sense_t sense_async
);
    // Current only tapers to the end threshold while the stage holds voltage,
    // so a sequencer that skips CV never sees the end-of-charge comparator.
    always_comb begin
        sense_async = env;
        sense_async.batt_at_eoc = env.batt_at_eoc & drive.cv_mode;
    end
endmodule
`default_nettype wire

// ### bench/liion_charge_sequencer_bench.sv
// Self-checking sequence test of the charge sequencer through its register port.
`timescale 1ns/1ns
`default_nettype none
module liion_charge_sequencer_bench
    import lcs_pkg::*;
;
    // A short second keeps the hour-long limits inside the run.
    localparam int unsigned SEC = 4;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    lcs_sense_t env = '0;
    lcs_sense_t sense;
    lcs_drive_t drive;
    logic sb2;
    logic sb1;
    logic sb0;
    logic irq;
    logic [2:0] sts;
    int miscompares = 0;
    int checked = 0;

    assign sts = {sb2, sb1, sb0};

    lcs_charge_sequencer #(.SEC_CYCLES(SEC)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sense_async(sense), .drive(drive), .charge_state_bit2(sb2),
        .charge_state_bit1(sb1), .charge_state_bit0(sb0), .irq(irq)
    );

    lcs_analog_model u_model (.env(env), .drive(drive), .sense_async(sense));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Every bench action lands 1 ns after a rising edge.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // The strobe drops for a full cycle so back-to-back calls never retrigger in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick(1);
        reg_rd_en = 1'b0;
        tick(1);
        chk(n, 11'(e), 11'(reg_rdata));
    endtask

    // Bounded wait for a status code, then compare it.
    task automatic wait_sts(input logic [2:0] e, input int max);
        int i;
        for (i = 0; i < max && sts !== e; i++) begin
            tick(1);
        end
        chk("status", 11'(e), 11'(sts));
    endtask

    task automatic conclude();
        $display("Totals checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is about 19600 cycles; cut off at just over twice that.
    initial begin
        #420000;
        miscompares++;
        $display("Watchdog expired before the tests ended");
        conclude();
    end

    // Main sequence.
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        tick(1);
        rd(CHG_CTL_OFS, CHG_CTL_RST, "ctl reset");
        rd(SUPV_OFS, 8'h30, "supv reset");
        rd(8'h07, 8'h00, "unmapped read");
        wr(CHG_CTL_OFS, 8'h8E);
        rd(CHG_CTL_OFS, 8'h8E, "ctl rw");
        $display("Test registers done");
        // 400 mA code, 4.38 V, 5 percent end threshold.
        env.adapter_supply_input = 1'b1;
        wait_sts(STS_PREQ, 10);
        chk("prequal ma", 11'h028, drive.current_ma);
        chk("eoc ma", 11'h014, drive.eoc_ma);
        chk("vterm", 11'h002, 11'(drive.vterm_sel));
        env.adapter_supply_input = 1'b0;
        env.usb_supply_input = 1'b1;
        tick(6);
        chk("usb prequal ma", 11'h032, drive.current_ma);
        chk("usb prequal", 11'(STS_PREQ), 11'(sts));
        env.adapter_supply_input = 1'b1;
        env.usb_supply_input = 1'b0;
        env.fullrate_qualify_threshold = 1'b1;
        wait_sts(STS_CC, 10);
        chk("cc ma", 11'h190, drive.current_ma);
        env.batt_at_vterm = 1'b1;
        wait_sts(STS_CV, 10);
        chk("cv mode", 11'h001, 11'(drive.cv_mode));
        env.batt_at_eoc = 1'b1;
        wait_sts(STS_TOPOFF, 10);
        tick(4900);
        chk("topoff holds", 11'(STS_TOPOFF), 11'(sts));
        wait_sts(STS_DONE, 300);
        chk("done off", 11'h000, 11'(drive.charge_on));
        env.batt_at_eoc = 1'b0;
        env.batt_at_vterm = 1'b0;
        env.batt_below_restart = 1'b1;
        wait_sts(STS_CC, 10);
        env.batt_below_restart = 1'b0;
        $display("Test charge cycle done");
        wr(CHG_CTL_OFS, 8'h8C);
        wait_sts(STS_OFF, 10);
        chk("disabled off", 11'h000, 11'(drive.charge_on));
        wr(CHG_CTL_OFS, 8'h8E);
        wait_sts(STS_CC, 10);
        // A 47 degree battery is legal until the narrow window is chosen.
        env.temp_hot45 = 1'b1;
        tick(6);
        chk("wide window", 11'(STS_CC), 11'(sts));
        wr(SUPV_OFS, 8'h38);
        wait_sts(STS_FAULT, 10);
        rd(SUPV_OFS, 8'h3C, "supv fault");
        env.temp_hot45 = 1'b0;
        wait_sts(STS_CC, 10);
        env.temp_cold = 1'b1;
        wait_sts(STS_FAULT, 10);
        chk("cold off", 11'h000, 11'(drive.charge_on));
        $display("Test disable and temperature done");
        env.temp_cold = 1'b0;
        env.fullrate_qualify_threshold = 1'b0;
        wait_sts(STS_PREQ, 10);
        tick(14200);
        chk("prequal holds", 11'(STS_PREQ), 11'(sts));
        chk("irq low", 11'h000, 11'(irq));
        wait_sts(STS_TMO, 400);
        chk("irq high", 11'h001, 11'(irq));
        rd(IRQ_STAT_OFS, 8'h01, "timeout flag");
        env.fullrate_qualify_threshold = 1'b1;
        tick(6);
        chk("stays stopped", 11'(STS_TMO), 11'(sts));
        wr(IRQ_STAT_OFS, 8'h01);
        chk("irq cleared", 11'h000, 11'(irq));
        wr(CHG_CTL_OFS, 8'h8C);
        wr(CHG_CTL_OFS, 8'h8E);
        wait_sts(STS_CC, 10);
        $display("Test safety timer done");
        conclude();
    end
endmodule
`default_nettype wire
